// ==== design/alu_status_flags.sv ====
/*
 * 8-bit ALU with its five status flags and a software view of the
 * flag register over a plain strobe port.
 * Assumes one clock, inputs synchronous to it, and an execution path
 * that pulses op_valid once per operation with stable operands.
 */
// Summary of operation
// RULE1: sign flag copies result bit 7.
// RULE2: signed-wrap flag set when signed result leaves 7-bit magnitude range.
// RULE3: zero flag set when arithmetic or logic result is all zeros.
// RULE4: half-carry flag holds carry out of bit 3 on add and subtract.
// RULE5: rotates load half-carry from source bit 4 (right) or 3 (left).
// RULE6: carry flag holds carry out of bit 7 on add and subtract.
// RULE7: subtract adds two's complement; carry one means no borrow.
// RULE8: rotates load carry from source bit 0 (right) or 7 (left).
// RULE9: half-carry is inverted digit borrow during subtraction.
// RULE10: flag register as destination of flag-setting op keeps ALU flags.
// RULE11: bits 7 to 5 read zero, ignore writes; flags undefined at power-on.
`default_nettype none

`include "alu_status_flags_defines.svh"

module alu_status_flags #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 8,
    parameter logic [4:0] FLAG_INIT = 5'h00
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic op_valid,
    input wire alu_flags_pkg::alu_op_e op,
    input wire logic [DATA_W-1:0] opnd_f,
    input wire logic [DATA_W-1:0] opnd_w,
    input wire logic dest_is_flags,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output var logic [DATA_W-1:0] result,
    output var logic result_valid,
    output var logic [`FLG_NUM-1:0] flags,
    output var logic [DATA_W-1:0] rd_data
);

    // the flag layout is fixed to a byte wide data path
    if (DATA_W != `FLG_REG_W || ADDR_W < 1) begin : g_param_check
        $error("alu_status_flags: DATA_W must be 8 and ADDR_W positive");
    end

    ////////////////////////////////////////////////////////////////////////
    // operation decode

    logic is_add;
    logic is_sub;
    logic is_arith;
    logic is_rot_r;
    logic is_rot_l;
    logic is_rot;
    logic is_logic;
    logic is_move;

    // adds and subtracts share one adder
    assign is_add = (op == alu_flags_pkg::OP_ADD_W_TO_F)
                 || (op == alu_flags_pkg::OP_ADD_LITERAL_TO_W);
    assign is_sub = (op == alu_flags_pkg::OP_LITERAL_MINUS_W)
                 || (op == alu_flags_pkg::OP_F_MINUS_W);
    assign is_arith = is_add || is_sub;
    assign is_rot_r = (op == alu_flags_pkg::OP_ROTATE_RIGHT_F);
    assign is_rot_l = (op == alu_flags_pkg::OP_ROTATE_LEFT_F);
    assign is_rot = is_rot_r || is_rot_l;
    assign is_logic = (op == alu_flags_pkg::OP_AND)
                   || (op == alu_flags_pkg::OP_IOR)
                   || (op == alu_flags_pkg::OP_XOR);
    assign is_move = (op == alu_flags_pkg::OP_MOVE);

    ////////////////////////////////////////////////////////////////////////
    // adder: a subtract is the sum with the inverted operand plus one

    logic [DATA_W-1:0] addend;
    logic carry_in;
    logic [DATA_W:0] sum;
    logic [`NIB_W:0] nib_sum;

    assign addend = is_sub ? ~opnd_w : opnd_w; // RULE7
    assign carry_in = is_sub; // RULE7
    assign sum = {1'b0, opnd_f} + {1'b0, addend} + {{DATA_W{1'b0}}, carry_in};
    // low nibble alone gives the digit carry
    assign nib_sum = {1'b0, opnd_f[`NIB_W-1:0]} + {1'b0, addend[`NIB_W-1:0]}
                   + {{`NIB_W{1'b0}}, carry_in};

    ////////////////////////////////////////////////////////////////////////
    // result and raw flag values

    logic [DATA_W-1:0] alu_res;
    logic [`FLG_NUM-1:0] flags_q;
    logic [`FLG_NUM-1:0] alu_flg;
    logic [`FLG_NUM-1:0] upd_mask;

    // rotates pass through the carry, so the old carry is an operand
    always_comb begin
        unique case (op)
            alu_flags_pkg::OP_ADD_W_TO_F,
            alu_flags_pkg::OP_ADD_LITERAL_TO_W,
            alu_flags_pkg::OP_LITERAL_MINUS_W,
            alu_flags_pkg::OP_F_MINUS_W: alu_res = sum[DATA_W-1:0];
            alu_flags_pkg::OP_ROTATE_RIGHT_F: begin
                alu_res = {flags_q[`FLG_C], opnd_f[DATA_W-1:1]};
            end
            alu_flags_pkg::OP_ROTATE_LEFT_F: begin
                alu_res = {opnd_f[DATA_W-2:0], flags_q[`FLG_C]};
            end
            alu_flags_pkg::OP_AND: alu_res = opnd_f & opnd_w;
            alu_flags_pkg::OP_IOR: alu_res = opnd_f | opnd_w;
            alu_flags_pkg::OP_XOR: alu_res = opnd_f ^ opnd_w;
            default: alu_res = opnd_w; // move, and unused codes
        endcase
    end

    // flag values as the hardware computes them
    assign alu_flg[`FLG_N] = alu_res[`DATA_MSB]; // RULE1
    // wrap: like-signed inputs giving an unlike-signed sum
    assign alu_flg[`FLG_WRAP] = (opnd_f[`DATA_MSB] == addend[`DATA_MSB])
                           && (alu_res[`DATA_MSB] != opnd_f[`DATA_MSB]); // RULE2
    assign alu_flg[`FLG_Z] = (alu_res == '0); // RULE3
    // on subtract the nibble carry is already an inverted borrow
    assign alu_flg[`FLG_HALF] = is_rot_r ? opnd_f[`NIB_W]
                           : is_rot_l ? opnd_f[`NIB_W-1]
                           : nib_sum[`NIB_W]; // RULE4 RULE5 RULE9
    assign alu_flg[`FLG_C] = is_rot_r ? opnd_f[0]
                          : is_rot_l ? opnd_f[`DATA_MSB]
                          : sum[DATA_W]; // RULE6 RULE7 RULE8

    // which flags each class of operation touches
    assign upd_mask[`FLG_N] = is_arith || is_rot || is_logic;
    assign upd_mask[`FLG_WRAP] = is_arith;
    assign upd_mask[`FLG_Z] = is_arith || is_rot || is_logic;
    assign upd_mask[`FLG_HALF] = is_arith || is_rot;
    assign upd_mask[`FLG_C] = is_arith || is_rot;

    ////////////////////////////////////////////////////////////////////////
    // flag register next value

    logic [`FLG_NUM-1:0] flags_d;
    logic [`FLG_NUM-1:0] op_flags;
    logic op_touches;
    logic bus_hit;
    logic bus_wr;
    logic wb_move;

    assign op_touches = op_valid && (upd_mask != '0);
    assign bus_hit = (addr == ADDR_W'(`FLAG_REG_ADDR));
    assign bus_wr = wr_en && bus_hit;
    // a move into the flag register is an ordinary data write
    assign wb_move = op_valid && is_move && dest_is_flags;

    // per bit: the ALU outcome where the op touches it, else the old bit
    genvar gi;
    generate
        for (gi = 0; gi < `FLG_NUM; gi++) begin : g_flag
            assign op_flags[gi] = upd_mask[gi] ? alu_flg[gi] : flags_q[gi];
        end
    endgenerate

    // an op that sets flags blocks its own writeback and any bus write
    assign flags_d = op_touches ? op_flags // RULE10
                   : wb_move ? alu_res[`FLG_NUM-1:0]
                   : bus_wr ? wr_data[`FLG_NUM-1:0] // RULE11
                   : flags_q;

    // reset gives a defined start although software may not rely on it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flags_q <= FLAG_INIT; // RULE11
        end else begin
            flags_q <= flags_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result port and read port

    logic [DATA_W-1:0] result_q;
    logic result_valid_q;
    logic [DATA_W-1:0] rd_data_q;
    logic [DATA_W-1:0] rd_word;

    // upper bits are unimplemented and read as zero
    assign rd_word = (rd_en && bus_hit)
                   ? {{(DATA_W-`FLG_NUM){1'b0}}, flags_q} // RULE11
                   : '0;

    // read data stand for the one cycle after the strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            result_q <= '0;
            result_valid_q <= 1'b0;
            rd_data_q <= '0;
        end else begin
            result_q <= op_valid ? alu_res : result_q;
            result_valid_q <= op_valid;
            rd_data_q <= rd_word;
        end
    end

    assign result = result_q;
    assign result_valid = result_valid_q;
    assign flags = flags_q;
    assign rd_data = rd_data_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_sign_follows: assert property ( // RULE1
        @(posedge ref_clk) disable iff (rst)
        (op_valid && upd_mask[`FLG_N])
        |=> (flags_q[`FLG_N] == result_q[`DATA_MSB]) && result_valid_q
    ) else $error("sign flag differs from result bit 7");

    a_wrap_add: assert property ( // RULE2
        @(posedge ref_clk) disable iff (rst)
        (op_valid && is_add && !opnd_f[`DATA_MSB] && !opnd_w[`DATA_MSB])
        |=> (flags_q[`FLG_WRAP] == result_q[`DATA_MSB])
    ) else $error("signed wrap flag wrong on positive add");

    a_zero_flag: assert property ( // RULE3
        @(posedge ref_clk) disable iff (rst)
        (op_valid && (is_arith || is_logic))
        |=> (flags_q[`FLG_Z] == (result_q == '0))
    ) else $error("zero flag disagrees with result");

    a_half_carry: assert property ( // RULE4
        @(posedge ref_clk) disable iff (rst)
        (op_valid && is_add)
        |=> flags_q[`FLG_HALF] == ((($past(opnd_f) & 8'h0F)
                                + ($past(opnd_w) & 8'h0F)) > 8'h0F)
    ) else $error("half carry wrong on add");

    a_rot_half: assert property ( // RULE5
        @(posedge ref_clk) disable iff (rst)
        (op_valid && is_rot)
        |=> flags_q[`FLG_HALF] == ($past(is_rot_r) ? $past(opnd_f[`NIB_W])
                                                : $past(opnd_f[`NIB_W-1]))
    ) else $error("half carry not loaded from source on rotate");

    a_carry_add: assert property ( // RULE6
        @(posedge ref_clk) disable iff (rst)
        (op_valid && is_add)
        |=> flags_q[`FLG_C] == ({1'b0, $past(opnd_f)} + {1'b0, $past(opnd_w)} > 9'h0FF)
    ) else $error("carry wrong on add");

    a_borrow_sub: assert property ( // RULE7
        @(posedge ref_clk) disable iff (rst)
        (op_valid && is_sub)
        |=> (flags_q[`FLG_C] == ($past(opnd_f) >= $past(opnd_w)))
            && (result_q == $past(opnd_f) - $past(opnd_w))
    ) else $error("borrow polarity or difference wrong");

    a_rot_carry: assert property ( // RULE8
        @(posedge ref_clk) disable iff (rst)
        (op_valid && is_rot_r)
        |=> (flags_q[`FLG_C] == $past(opnd_f[0]))
            && (result_q[`DATA_MSB] == $past(flags_q[`FLG_C]))
    ) else $error("rotate right carry wrong");

    a_digit_borrow: assert property ( // RULE9
        @(posedge ref_clk) disable iff (rst)
        (op_valid && is_sub)
        |=> flags_q[`FLG_HALF] == (($past(opnd_f) & 8'h0F) >= ($past(opnd_w) & 8'h0F))
    ) else $error("digit borrow polarity wrong");

    a_dest_blocked: assert property ( // RULE10
        @(posedge ref_clk) disable iff (rst)
        (op_valid && dest_is_flags && is_arith)
        |=> (flags_q[`FLG_Z] == (result_q == '0))
    ) else $error("flag writeback overrode ALU flags");

    a_upper_zero: assert property ( // RULE11
        @(posedge ref_clk) disable iff (rst)
        rd_en |=> (rd_data_q[DATA_W-1:`FLG_NUM] == '0)
    ) else $error("unimplemented flag bits read nonzero");

    a_read_once: assert property ( // RULE11
        @(posedge ref_clk) disable iff (rst)
        (rd_en && bus_hit && !op_valid && !wr_en) ##1 !(op_valid || wr_en)
        |=> ($past(rd_data_q[`FLG_NUM-1:0]) == flags_q)
    ) else $error("read data do not show the flag register");

    a_rot_left: assert property ( // RULE8
        @(posedge ref_clk) disable iff (rst)
        (op_valid && is_rot_l)
        |=> (flags_q[`FLG_C] == $past(opnd_f[`DATA_MSB]))
            && (result_q[0] == $past(flags_q[`FLG_C]))
    ) else $error("rotate left carry wrong");

    a_wrap_sub: assert property ( // RULE2
        @(posedge ref_clk) disable iff (rst)
        (op_valid && is_sub && !opnd_f[`DATA_MSB] && opnd_w[`DATA_MSB])
        |=> (flags_q[`FLG_WRAP] == result_q[`DATA_MSB])
    ) else $error("signed wrap flag wrong on subtract");

    // a logic op keeps wrap, half-carry and carry even against a bus write
    a_write_lost: assert property ( // RULE10
        @(posedge ref_clk) disable iff (rst)
        (op_valid && is_logic && bus_wr)
        |=> ({flags_q[`FLG_WRAP], flags_q[`FLG_HALF], flags_q[`FLG_C]}
             == $past({flags_q[`FLG_WRAP], flags_q[`FLG_HALF], flags_q[`FLG_C]}))
    ) else $error("software write overrode a flag-setting op");

endmodule : alu_status_flags

`default_nettype wire

// ==== design/alu_status_flags_defines.svh ====
/*
 * Bit positions, widths and the software address of the ALU flag register.
 * Assumes it is included once per compilation unit by its bare name.
 */
`ifndef ALU_STATUS_FLAGS_DEFINES_SVH
`define ALU_STATUS_FLAGS_DEFINES_SVH

// flag positions inside the flag register
`define FLG_C 0
`define FLG_HALF 1
`define FLG_Z 2
`define FLG_WRAP 3
`define FLG_N 4

// number of implemented flags, width of the register
`define FLG_NUM 5
`define FLG_REG_W 8

// data path geometry
`define DATA_MSB 7
`define NIB_W 4

// software address of the flag register
`define FLAG_REG_ADDR 8'h00

`endif

// ==== design/alu_flags_pkg.sv ====
/*
 * Types shared by the flag block and its users: the ALU operation codes.
 * Assumes the execution path presents one code per issued operation.
 */
`default_nettype none

package alu_flags_pkg;

    // operations the block executes
    typedef enum logic [3:0] {
        OP_ADD_W_TO_F = 4'h0,
        OP_ADD_LITERAL_TO_W = 4'h1,
        OP_LITERAL_MINUS_W = 4'h2,
        OP_F_MINUS_W = 4'h3,
        OP_ROTATE_RIGHT_F = 4'h4,
        OP_ROTATE_LEFT_F = 4'h5,
        OP_AND = 4'h6,
        OP_IOR = 4'h7,
        OP_XOR = 4'h8,
        OP_MOVE = 4'h9
    } alu_op_e;

endpackage : alu_flags_pkg

`default_nettype wire

// ==== tb/exec_path_model.sv ====
/*
 * Model of the execution path: issues ALU operations to the flag block.
 * Assumes a free-running ref_clk; the caller paces and releases the requests.
 */
`default_nettype none

module exec_path_model (
    input wire logic ref_clk,
    output var logic op_valid,
    output var alu_flags_pkg::alu_op_e op,
    output var logic [7:0] opnd_f,
    output var logic [7:0] opnd_w,
    output var logic dest_is_flags
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle at time zero
    initial begin
        op_valid = 1'b0;
        op = alu_flags_pkg::OP_MOVE;
        opnd_f = 8'h00;
        opnd_w = 8'h00;
        dest_is_flags = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one operation per call; back-to-back calls keep op_valid high
    task automatic issue(input alu_flags_pkg::alu_op_e o, input logic [7:0] f,
                         input logic [7:0] w, input logic d);
        @(posedge ref_clk);
        op_valid <= 1'b1;
        op <= o;
        opnd_f <= f;
        opnd_w <= w;
        dest_is_flags <= d;
    endtask : issue

    // operands flip on release so stale values never pass for fresh ones
    task automatic idle();
        @(posedge ref_clk);
        op_valid <= 1'b0;
        opnd_f <= ~opnd_f;
        opnd_w <= ~opnd_w;
        dest_is_flags <= 1'b0;
    endtask : idle
endmodule : exec_path_model

`default_nettype wire

// ==== tb/tb_top.sv ====
/*
 * Self-checking bench for the ALU flag block: random and corner operations,
 * flag register reads and writes over the strobe port.
 * Assumes the flag register sits at address 8'h00 and flags are, from bit 4
 * down: sign, signed wrap, zero, half-carry, carry.
 */
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {logic [7:0] r; logic [4:0] fl;} exp_s;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic op_valid, dest_is_flags;
    alu_flags_pkg::alu_op_e op;
    logic [7:0] opnd_f, opnd_w, result, rd_data;
    logic result_valid;
    logic [4:0] flags;
    logic [4:0] exp_flags;
    exp_s exp_q[$];
    int bad_count = 0;
    int checks = 0;

    always #5 ref_clk = ~ref_clk;

    exec_path_model exec_path_model_i (.ref_clk(ref_clk), .op_valid(op_valid), .op(op),
        .opnd_f(opnd_f), .opnd_w(opnd_w), .dest_is_flags(dest_is_flags));
    alu_status_flags alu_status_flags_i (.ref_clk(ref_clk), .rst(rst), .op_valid(op_valid),
        .op(op), .opnd_f(opnd_f), .opnd_w(opnd_w), .dest_is_flags(dest_is_flags),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .result(result),
        .result_valid(result_valid), .flags(flags), .rd_data(rd_data));

    ////////////////////////////////////////////////////////////////////////////
    // compare tasks, one per width of result
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: byte got %h expected %h", $time, got, exp);
        end
    endtask : cmp8

    task automatic cmp5(input logic [4:0] got, input logic [4:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: flags got %b expected %b", $time, got, exp);
        end
    endtask : cmp5

    // reference: result and flags from operands and the flags before the op
    function automatic exp_s model(input alu_flags_pkg::alu_op_e o, input logic [7:0] f,
                                   input logic [7:0] w, input logic [4:0] fl, input logic d);
        exp_s e;
        logic sub;
        logic [7:0] wo;
        logic [8:0] s;
        logic [4:0] lo;
        sub = (o == alu_flags_pkg::OP_LITERAL_MINUS_W) || (o == alu_flags_pkg::OP_F_MINUS_W);
        wo = sub ? ~w : w;
        s = {1'b0, f} + {1'b0, wo} + {8'h00, sub};
        lo = {1'b0, f[3:0]} + {1'b0, wo[3:0]} + {4'h0, sub};
        e.fl = fl;
        case (o)
            alu_flags_pkg::OP_ROTATE_RIGHT_F: e.r = {fl[0], f[7:1]};
            alu_flags_pkg::OP_ROTATE_LEFT_F: e.r = {f[6:0], fl[0]};
            alu_flags_pkg::OP_AND: e.r = f & w;
            alu_flags_pkg::OP_IOR: e.r = f | w;
            alu_flags_pkg::OP_XOR: e.r = f ^ w;
            alu_flags_pkg::OP_MOVE: e.r = w;
            default: e.r = s[7:0];
        endcase
        if (o <= alu_flags_pkg::OP_F_MINUS_W) begin
            e.fl[0] = s[8];
            e.fl[1] = lo[4];
            e.fl[3] = (f[7] == wo[7]) && (s[7] != f[7]);
        end
        if (o == alu_flags_pkg::OP_ROTATE_RIGHT_F) e.fl[1:0] = {f[4], f[0]};
        if (o == alu_flags_pkg::OP_ROTATE_LEFT_F) e.fl[1:0] = {f[3], f[7]};
        if (o != alu_flags_pkg::OP_MOVE) e.fl[4] = e.r[7];
        if (o != alu_flags_pkg::OP_MOVE) e.fl[2] = (e.r == 8'h00);
        if (o == alu_flags_pkg::OP_MOVE && d) e.fl = w[4:0];
        return e;
    endfunction : model

    ////////////////////////////////////////////////////////////////////////////
    // issue one op and queue what it should produce
    task automatic alu(input alu_flags_pkg::alu_op_e o, input logic [7:0] f,
                       input logic [7:0] w, input logic d);
        exp_s e;
        e = model(o, f, w, exp_flags, d);
        exp_flags = e.fl;
        exp_q.push_back(e);
        exec_path_model_i.issue(o, f, w, d);
    endtask : alu

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask : reg_wr

    // read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 cmp8(rd_data, exp);
        @(posedge ref_clk);
        #1 cmp8(rd_data, 8'h00);
    endtask : reg_rd

    // every result pulse matches the oldest queued op
    always @(negedge ref_clk) begin
        if (result_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                cmp8(8'hFF, 8'h00);
            end else begin
                cmp8(result, exp_q[0].r);
                cmp5(flags, exp_q[0].fl);
                void'(exp_q.pop_front());
            end
        end
    end

    task automatic summarize();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize

    initial begin
        #100us;
        bad_count++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h8FD6));
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        // reset loads FLAG_INIT, which software may not rely on, so load the flags first
        reg_wr(8'h00, 8'hFF);
        exp_flags = 5'h1F;
        reg_rd(8'h00, 8'h1F);
        reg_wr(8'h01, 8'h00);
        reg_rd(8'h01, 8'h00);
        reg_wr(8'h00, 8'hEA);
        exp_flags = 5'h0A;
        reg_rd(8'h00, 8'h0A);
        // corners: signed wrap, zero with carry, borrow, equal subtract
        alu(alu_flags_pkg::OP_ADD_W_TO_F, 8'h7F, 8'h01, 1'b0);
        alu(alu_flags_pkg::OP_ADD_LITERAL_TO_W, 8'hFF, 8'h01, 1'b1);
        alu(alu_flags_pkg::OP_LITERAL_MINUS_W, 8'h00, 8'h01, 1'b0);
        alu(alu_flags_pkg::OP_F_MINUS_W, 8'h80, 8'h80, 1'b0);
        alu(alu_flags_pkg::OP_MOVE, 8'h00, 8'hF5, 1'b1);
        for (int k = 0; k < 300; k++) begin
            alu(alu_flags_pkg::alu_op_e'($urandom_range(0, 9)), 8'($urandom),
                8'($urandom), ($urandom_range(0, 3) == 0));
        end
        exec_path_model_i.idle();
        // software write in the same cycle as a flag-setting op is lost
        fork
            begin
                alu(alu_flags_pkg::OP_AND, 8'hF0, 8'h0F, 1'b0);
                exec_path_model_i.idle();
            end
            reg_wr(8'h00, 8'h1F);
        join
        reg_rd(8'h00, {3'b000, exp_flags});
        repeat (3) @(posedge ref_clk);
        cmp8(8'(exp_q.size()), 8'h00);
        summarize();
    end
endmodule : tb_top

`default_nettype wire
